/* File: design/eeprom_spi_pkg.sv */
// Package: constants and carrier types for the serial EEPROM command slave
package eeprom_spi_pkg;
    // ----------------------------------------
    // Opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int ADDR_W = 15;
    localparam int MEM_BYTES = 32768;
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_W = 6;
    localparam int FIFO_DEPTH = 16;
    // ----------------------------------------
    // Status field positions
    // ----------------------------------------
    localparam int ST_HPE = 7;
    localparam int ST_BP_HI = 3;
    localparam int ST_BP_LO = 2;
    localparam int ST_WEL = 1;
    localparam int ST_WIP = 0;
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic HPE_RESET = 1'b0;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int WRITE_CYCLE_US = 5000;
    localparam int WRITE_CYCLES = WRITE_CYCLE_US * CLK_MHZ;
    // ----------------------------------------
    // Carrier
    // ----------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } page_word_s;
endpackage

/* File: design/page_fifo.sv */
// Small valid/ready FIFO for buffered page bytes
`timescale 1ns/1ps
module page_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (ce) begin
            if (flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
            end
        end
    end
    chk_no_overflow: assert property (@(posedge clk) disable iff (!rst_n) full |-> !push)
        else $error("FIFO pushed while full");
endmodule

/* File: design/spi_eeprom_slave.sv */
// Serial EEPROM command slave: SPI front end, status, page buffer and array
`timescale 1ns/1ps
//
// Contract
// [RL1] Eight-bit instruction register captures each input bit on rising serial clock.
// [RL2] Host keeps select low and pause high for whole operation.
// [RL3] All instruction, address and data bytes travel most significant bit first.
// [RL4] First bit taken on first rising clock after select falls.
// [RL5] Pause freezes the sequence; release resumes at the same bit.
// [RL6] Read takes 16-bit address, top bit ignored, then shifts out data.
// [RL7] Read pointer advances one after each byte shifted out.
// [RL8] Sequential read wraps from top address to zero.
// [RL9] Read runs until select rises, which ends it.
// [RL10] Set-latch acts only when select rises after all eight bits.
// [RL11] Write takes 16-bit address, top bit ignored, then 1 to 64 bytes. The 16-entry page buffer keeps only the first 16 bytes and the last one.
// [RL12] Write data past page end wraps within the same page.
// [RL13] Write commits only if select rises after a whole data byte.
// [RL14] During internal write array reads are refused; status reads still work.
// [RL15] Latch cleared at reset, clear-latch, status write and array write end.
// [RL16] Read opcode 03h, write opcode 02h, address follows.
// [RL17] Set-latch opcode 06h, clear-latch opcode 04h.
// [RL18] Status read 05h and status write 01h; status readable always.
// [RL19] Status: protect enable 7, block protect 3:2, latch 1, busy 0.
// [RL20] Busy flag reads one while internal write runs, else zero.
// [RL21] Latch bit reads one when writes allowed; latch commands always work.
// [RL22] Block-protect bits change only by status write.
// [RL23] Block protect 00 none, 01 top quarter, 10 top half, 11 all.
// [RL24] Protect pin low with protect enable high blocks status writes.
// [RL25] Output updates after each falling serial clock edge.
// [RL26] Internal write is a counted cycle with busy high, latch cleared at end.
module spi_eeprom_slave #(
    parameter int WRITE_CYCLES = eeprom_spi_pkg::WRITE_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI,
    input wire logic HOLD_N,
    input wire logic WP_N,
    output logic SO,
    output logic SO_OE,
    output logic [7:0] STATUS_BYTE
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RDATA = 3'b010,
        ST_WDATA = 3'b011,
        ST_STATUS_RD = 3'b100,
        ST_STATUS_WR = 3'b101,
        ST_IGNORE = 3'b110
    } phase_e;
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] cs_s1, cs_s2;
    logic [1:0] sck_s1, sck_s2;
    logic [1:0] misc_s1, misc_s2;
    logic si_s1, si_s2;
    logic sck_d, cs_d;
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {cs_s1, sck_s1, misc_s1, si_s1} <= 7'h3e;
            {cs_s2, sck_s2, misc_s2, si_s2} <= 7'h3e;
            sck_d <= 1'b0;
            cs_d <= 1'b1;
        end else if (CLK_EN) begin
            cs_s1 <= {1'b0, CS_N};
            sck_s1 <= {1'b0, SCK};
            misc_s1 <= {HOLD_N, WP_N};
            si_s1 <= SI;
            cs_s2 <= cs_s1;
            sck_s2 <= sck_s1;
            misc_s2 <= misc_s1;
            si_s2 <= si_s1;
            sck_d <= sck_s2[0];
            cs_d <= cs_s2[0];
        end
    end
    wire cs_n_q = cs_s2[0];
    wire hold_q = misc_s2[1];
    wire wp_q = misc_s2[0];
    wire active = !cs_n_q && hold_q; // [RL5]
    wire sck_rise = active && sck_s2[0] && !sck_d; // [RL1] [RL4]
    wire sck_fall = active && !sck_s2[0] && sck_d; // [RL25]
    wire cs_rise = cs_n_q && !cs_d;
    // ----------------------------------------
    // Array, status and protection
    // ----------------------------------------
    logic [7:0] mem [eeprom_spi_pkg::MEM_BYTES];
    logic hw_protect_enable;
    logic block_protect_hi, block_protect_lo;
    logic write_enable_latch;
    logic write_in_progress;
    logic [31:0] wc_count;
    function automatic logic addr_protected(input logic [1:0] bp, input logic [14:0] a);
        case (bp)
            2'h0: addr_protected = 1'b0;
            2'h1: addr_protected = a[14] & a[13];
            2'h2: addr_protected = a[14];
            default: addr_protected = 1'b1;
        endcase
    endfunction
    wire [1:0] bp = {block_protect_hi, block_protect_lo};
    wire status_locked = !wp_q && hw_protect_enable; // [RL24]
    assign STATUS_BYTE = {hw_protect_enable, 3'h0, block_protect_hi, block_protect_lo,
                          write_enable_latch, write_in_progress}; // [RL19] [RL20] [RL21]
    // ----------------------------------------
    // Serial shifter
    // ----------------------------------------
    phase_e phase;
    logic [7:0] shift_in;
    logic [2:0] bit_cnt;
    logic [7:0] opcode;
    logic [15:0] addr_sr;
    logic addr_byte;
    logic [14:0] ptr;
    logic [7:0] out_sr;
    logic byte_done_ok;
    logic [7:0] status_new;
    logic status_pending;
    logic [14:0] page_base;
    logic [5:0] page_off;
    wire [7:0] next_byte = {shift_in[6:0], si_s2}; // [RL3]
    wire last_bit = (bit_cnt == 3'h7);
    wire [14:0] next_addr = {addr_sr[6:0], next_byte}; // [RL6] [RL11]
    wire is_read = (opcode == eeprom_spi_pkg::OP_READ); // [RL16]
    wire is_write = (opcode == eeprom_spi_pkg::OP_WRITE); // [RL16]
    // FIFO carrier and handshake
    eeprom_spi_pkg::page_word_s fifo_in, fifo_out;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, flush;
    logic draining;
    wire [14:0] wr_addr = {page_base[14:6], page_off}; // [RL12]
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            phase <= ST_OPCODE;
            shift_in <= 8'h00;
            bit_cnt <= 3'h0;
            opcode <= 8'h00;
            addr_sr <= 16'h0000;
            addr_byte <= 1'b0;
            ptr <= 15'h0000;
            out_sr <= 8'h00;
            byte_done_ok <= 1'b0;
            status_new <= 8'h00;
            status_pending <= 1'b0;
            page_base <= 15'h0000;
            page_off <= 6'h00;
            fifo_in_valid <= 1'b0;
            fifo_in <= '0;
        end else if (CLK_EN) begin
            if (fifo_in_valid && fifo_in_ready) begin
                fifo_in_valid <= 1'b0;
            end
            if (cs_n_q) begin
                phase <= ST_OPCODE; // [RL9]
                bit_cnt <= 3'h0;
                addr_byte <= 1'b0;
                byte_done_ok <= 1'b0;
                status_pending <= 1'b0;
            end else if (sck_rise) begin
                shift_in <= next_byte; // [RL1]
                bit_cnt <= bit_cnt + 3'h1;
                byte_done_ok <= 1'b0;
                if (last_bit) begin
                    case (phase)
                        ST_OPCODE: begin
                            opcode <= next_byte;
                            if (next_byte == eeprom_spi_pkg::OP_READ || next_byte == eeprom_spi_pkg::OP_WRITE) begin
                                phase <= ST_ADDR;
                            end else if (next_byte == eeprom_spi_pkg::OP_READ_STATUS) begin
                                phase <= ST_STATUS_RD; // [RL18]
                            end else if (next_byte == eeprom_spi_pkg::OP_WRITE_STATUS) begin
                                phase <= ST_STATUS_WR;
                            end else begin
                                phase <= ST_IGNORE;
                                byte_done_ok <= 1'b1; // [RL10]
                            end
                        end
                        ST_ADDR: begin
                            addr_sr <= {addr_sr[7:0], next_byte};
                            addr_byte <= 1'b1;
                            if (addr_byte) begin
                                ptr <= next_addr;
                                page_base <= next_addr;
                                page_off <= next_addr[5:0];
                                if (is_read && !write_in_progress) begin
                                    phase <= ST_RDATA; // [RL14]
                                end else if (is_write && write_enable_latch && !write_in_progress) begin
                                    phase <= ST_WDATA;
                                end else begin
                                    phase <= ST_IGNORE;
                                end
                            end
                        end
                        ST_WDATA: begin
                            if (!addr_protected(bp, wr_addr)) begin // [RL23]
                                fifo_in <= '{addr: wr_addr, data: next_byte};
                                fifo_in_valid <= 1'b1;
                            end
                            page_off <= page_off + 6'h1; // [RL12]
                            byte_done_ok <= 1'b1; // [RL13]
                        end
                        ST_STATUS_WR: begin
                            status_new <= next_byte;
                            status_pending <= 1'b1;
                            byte_done_ok <= 1'b1;
                            phase <= ST_IGNORE;
                        end
                        default: begin
                        end
                    endcase
                end
            end else if (sck_fall) begin
                // Load next read byte and advance pointer on the same falling edge, before shift-out
                if (phase == ST_RDATA && bit_cnt == 3'h0) begin
                    out_sr <= mem[ptr];
                    ptr <= ptr + 15'h1; // [RL7] [RL8]
                end else if (phase == ST_STATUS_RD && bit_cnt == 3'h0) begin
                    out_sr <= STATUS_BYTE;
                end else begin
                    out_sr <= {out_sr[6:0], 1'b0}; // [RL25]
                end
            end
        end
    end
    assign SO = out_sr[7];
    assign SO_OE = !cs_n_q && hold_q && (phase == ST_RDATA || phase == ST_STATUS_RD);
    // ----------------------------------------
    // Commit on select rise
    // ----------------------------------------
    wire commit_ok = cs_rise && byte_done_ok && bit_cnt == 3'h0;
    wire set_latch_cmd = commit_ok && opcode == eeprom_spi_pkg::OP_SET_LATCH; // [RL10] [RL17]
    wire clear_latch_cmd = commit_ok && opcode == eeprom_spi_pkg::OP_CLEAR_LATCH; // [RL17]
    wire write_status_cmd = commit_ok && status_pending && write_enable_latch && !write_in_progress;
    wire array_commit = commit_ok && is_write; // [RL13]
    wire wc_done = write_in_progress && draining && !fifo_out_valid && wc_count == 32'h0;
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            write_enable_latch <= 1'b0; // [RL15]
            write_in_progress <= 1'b0;
            hw_protect_enable <= eeprom_spi_pkg::HPE_RESET;
            {block_protect_hi, block_protect_lo} <= eeprom_spi_pkg::BP_RESET;
            wc_count <= 32'h0;
            draining <= 1'b0;
        end else if (CLK_EN) begin
            if (set_latch_cmd) begin
                write_enable_latch <= 1'b1; // [RL21]
            end else if (clear_latch_cmd || wc_done) begin
                write_enable_latch <= 1'b0; // [RL15] [RL26]
            end
            if ((array_commit || write_status_cmd) && !write_in_progress) begin
                write_in_progress <= 1'b1; // [RL26]
                draining <= array_commit;
                wc_count <= 32'(WRITE_CYCLES - 1);
                if (write_status_cmd && !status_locked) begin
                    hw_protect_enable <= status_new[eeprom_spi_pkg::ST_HPE]; // [RL22] [RL24]
                    block_protect_hi <= status_new[eeprom_spi_pkg::ST_BP_HI];
                    block_protect_lo <= status_new[eeprom_spi_pkg::ST_BP_LO];
                end
            end else if (write_in_progress) begin
                if (wc_count != 32'h0) begin
                    wc_count <= wc_count - 32'h1;
                end else if (!fifo_out_valid) begin
                    write_in_progress <= 1'b0; // [RL20]
                    write_enable_latch <= set_latch_cmd; // [RL15]
                    draining <= 1'b0;
                end
            end
        end
    end
    // ----------------------------------------
    // Page buffer and array programming
    // ----------------------------------------
    assign flush = cs_rise && !array_commit && !write_in_progress;
    assign fifo_out_ready = write_in_progress && draining;
    page_fifo #(
        .WIDTH($bits(eeprom_spi_pkg::page_word_s)),
        .DEPTH(eeprom_spi_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .ce(CLK_EN),
        .flush(flush),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );
    always_ff @(posedge REF_CLK) begin
        if (CLK_EN && fifo_out_valid && fifo_out_ready) begin
            mem[fifo_out.addr] <= fifo_out.data;
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_busy_refuses_read: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [RL14]
        write_in_progress && phase == ST_ADDR |=> phase != ST_RDATA || $past(!write_in_progress))
        else $error("Array read entered while busy");
    chk_set_latch_commit: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [RL10]
        CLK_EN && set_latch_cmd |=> write_enable_latch)
        else $error("Latch not set after set-latch commit");
    chk_clear_latch: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [RL15]
        CLK_EN && clear_latch_cmd |=> !write_enable_latch)
        else $error("Latch not cleared");
    chk_busy_start: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [RL26]
        CLK_EN && array_commit && !write_in_progress |=> write_in_progress)
        else $error("Write cycle not started on commit");
    chk_busy_end_latch: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [RL26]
        $fell(write_in_progress) |-> !write_enable_latch)
        else $error("Latch left set after write cycle");
    chk_bp_stable: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [RL22]
        !$past(write_status_cmd) |-> $stable(bp))
        else $error("Block protect changed without status write");
    chk_page_wrap: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [RL12]
        phase == ST_WDATA |-> wr_addr[14:6] == page_base[14:6])
        else $error("Write left its page");
    chk_read_advance: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [RL7]
        CLK_EN && sck_fall && phase == ST_RDATA && bit_cnt == 3'h0 && !cs_n_q |=> ptr == $past(ptr) + 15'h1)
        else $error("Read pointer did not advance");
    chk_hold_freezes: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [RL5]
        !hold_q |=> $stable(bit_cnt) || $past(cs_n_q))
        else $error("Bit counter moved during pause");
    cov_read: cover property (@(posedge REF_CLK) phase == ST_RDATA);
    cov_commit: cover property (@(posedge REF_CLK) array_commit);
    cov_status_wr: cover property (@(posedge REF_CLK) write_status_cmd);
endmodule

/* File: dv/spi_host_model.sv */
// Host-side model of the serial bus master driving the EEPROM slave
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    input wire logic so,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    // ----------------------------------------
    // Idle levels: deselected, clock parked low
    // ----------------------------------------
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic start_frame();
        @(posedge clk);
        cs_n <= 1'b0;
        wait_clk(8);
    endtask

    task automatic end_frame();
        wait_clk(8);
        cs_n <= 1'b1;
        si <= ~si;
        wait_clk(8);
    endtask

    // One byte, MSB first, 160 ns clock; optional pause before bit 3
    task automatic xfer(input logic [7:0] tx, input bit pause, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            wait_clk(8);
            if (pause && i == 3) begin
                hold_n <= 1'b0;
                wait_clk(8);
                sck <= 1'b1;
                wait_clk(8);
                sck <= 1'b0;
                si <= ~tx[i];
                wait_clk(8);
                si <= tx[i];
                hold_n <= 1'b1;
                wait_clk(8);
            end
            rx[i] = so_oe ? so : 1'bz;
            sck <= 1'b1;
            wait_clk(8);
            sck <= 1'b0;
        end
    endtask
endmodule

/* File: dv/spi_eeprom_command_slave_tb.sv */
// Self-checking testbench for the serial EEPROM command slave
`timescale 1ns/1ps
module spi_eeprom_command_slave_tb;
    localparam int WCYC = 1000;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n = 1'b1;
    logic cs_n, sck, si, hold_n, so, so_oe;
    logic [7:0] status_byte;
    logic [7:0] rx;
    int num_errors = 0;
    int n_tests = 0;

    always #5 ref_clk = ~ref_clk;

    spi_eeprom_slave #(.WRITE_CYCLES(WCYC)) spi_eeprom_slave_inst (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .CLK_EN(1'b1), .CS_N(cs_n), .SCK(sck), .SI(si),
        .HOLD_N(hold_n), .WP_N(wp_n), .SO(so), .SO_OE(so_oe), .STATUS_BYTE(status_byte));

    spi_host_model spi_host_model_inst (
        .clk(ref_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic frame2(input logic [7:0] op, input logic [7:0] b, input bit two, output logic [7:0] v);
        spi_host_model_inst.start_frame();
        spi_host_model_inst.xfer(op, 1'b0, v);
        if (two) spi_host_model_inst.xfer(b, 1'b0, v);
        spi_host_model_inst.end_frame();
    endtask

    task automatic write_array(input logic [15:0] a, input logic [7:0] d[$]);
        spi_host_model_inst.start_frame();
        spi_host_model_inst.xfer(eeprom_spi_pkg::OP_WRITE, 1'b0, rx);
        spi_host_model_inst.xfer(a[15:8], 1'b0, rx);
        spi_host_model_inst.xfer(a[7:0], 1'b0, rx);
        foreach (d[i]) spi_host_model_inst.xfer(d[i], 1'b0, rx);
        spi_host_model_inst.end_frame();
    endtask

    task automatic read_array(input logic [15:0] a, input int n, input bit pause, output logic [7:0] q[$]);
        logic [7:0] v;
        q = {};
        spi_host_model_inst.start_frame();
        spi_host_model_inst.xfer(eeprom_spi_pkg::OP_READ, 1'b0, v);
        spi_host_model_inst.xfer(a[15:8], pause, v);
        spi_host_model_inst.xfer(a[7:0], 1'b0, v);
        repeat (n) begin
            spi_host_model_inst.xfer(8'hff, 1'b0, v);
            q.push_back(v);
        end
        spi_host_model_inst.end_frame();
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        while (status_byte[0] !== 1'b0 && n < 1500) begin
            @(posedge ref_clk);
            n++;
        end
        check(8'(n < 1500), 8'h01, "busy never cleared");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(status_byte, 8'h00, "status after reset");
        check({7'h00, so_oe}, 8'h00, "output enable after reset");
    endtask

    task automatic t_page_wrap();
        logic [7:0] q[$];
        int n;
        frame2(eeprom_spi_pkg::OP_SET_LATCH, 8'h00, 1'b0, rx);
        check(status_byte, 8'h02, "latch set");
        write_array(16'h003e, '{8'ha0, 8'ha1, 8'ha2, 8'ha3});
        check(status_byte, 8'h03, "busy after write");
        wait_idle(n);
        check(8'(n >= WCYC - 40), 8'h01, "write cycle too short");
        check(status_byte, 8'h00, "latch after write");
        read_array(16'h803e, 2, 1'b1, q);
        check(q[0], 8'ha0, "read first byte");
        check(q[1], 8'ha1, "read second byte");
        read_array(16'h0000, 2, 1'b0, q);
        check(q[0], 8'ha2, "page wrap byte 0");
        check(q[1], 8'ha3, "page wrap byte 1");
    endtask

    task automatic t_read_wrap();
        logic [7:0] q[$];
        logic [7:0] v;
        int n;
        frame2(eeprom_spi_pkg::OP_SET_LATCH, 8'h00, 1'b0, rx);
        write_array(16'h7fff, '{8'h5c});
        frame2(eeprom_spi_pkg::OP_READ_STATUS, 8'h00, 1'b1, v);
        check(v, 8'h03, "status read while busy");
        read_array(16'h0000, 1, 1'b0, q);
        check(q[0], 8'hzz, "array read while busy");
        wait_idle(n);
        read_array(16'h7fff, 3, 1'b0, q);
        check(q[0], 8'h5c, "top address");
        check(q[1], 8'ha2, "wrap to zero");
        check(q[2], 8'ha3, "after wrap");
    endtask

    task automatic t_protect();
        logic [7:0] q[$];
        int n;
        frame2(eeprom_spi_pkg::OP_SET_LATCH, 8'h00, 1'b0, rx);
        frame2(eeprom_spi_pkg::OP_WRITE_STATUS, 8'h8c, 1'b1, rx);
        wait_idle(n);
        check(status_byte, 8'h8c, "status written");
        frame2(eeprom_spi_pkg::OP_SET_LATCH, 8'h00, 1'b0, rx);
        write_array(16'h0000, '{8'h11});
        wait_idle(n);
        read_array(16'h0000, 1, 1'b0, q);
        check(q[0], 8'ha2, "protected array");
        wp_n <= 1'b0;
        frame2(eeprom_spi_pkg::OP_SET_LATCH, 8'h00, 1'b0, rx);
        check(status_byte, 8'h8e, "latch under protect");
        frame2(eeprom_spi_pkg::OP_WRITE_STATUS, 8'h00, 1'b1, rx);
        wait_idle(n);
        check(status_byte & 8'h8c, 8'h8c, "status write blocked");
        frame2(eeprom_spi_pkg::OP_CLEAR_LATCH, 8'h00, 1'b0, rx);
        check(status_byte, 8'h8c, "latch cleared");
        wp_n <= 1'b1;
        frame2(eeprom_spi_pkg::OP_SET_LATCH, 8'h00, 1'b0, rx);
        frame2(eeprom_spi_pkg::OP_WRITE_STATUS, 8'h00, 1'b1, rx);
        wait_idle(n);
        check(status_byte, 8'h00, "status restored");
    endtask

    task automatic t_no_latch();
        logic [7:0] q[$];
        write_array(16'h0001, '{8'h99});
        check(status_byte, 8'h00, "no write without latch");
        read_array(16'h0001, 1, 1'b0, q);
        check(q[0], 8'ha3, "array unchanged");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        t_reset();
        reset_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        t_reset();
        t_page_wrap();
        t_read_wrap();
        t_protect();
        t_no_latch();
        final_report();
    end

    initial begin
        #1000000;
        num_errors++;
        final_report();
    end
endmodule
